// ---- common/swf_pkg.sv ----
// Purpose: Shared constants and types for the status word and accumulator block
// Assumes: 8-bit special-function-register space, one clock
// Notes: Bit positions follow the status word layout
package swf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SWF_PSW_ADDR = 8'hd0;
  localparam logic [7:0] SWF_ACC_ADDR = 8'he0;
  localparam logic [7:0] SWF_PSW_RST = 8'h00;
  localparam logic [7:0] SWF_ACC_RST = 8'h00;
  localparam logic [7:0] SWF_AUX_RST = 8'h00;
  localparam logic [7:0] SWF_RDATA_RST = 8'h00;
  localparam logic [4:0] SWF_BASE_RST = 5'h00;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int SWF_CARRY_BIT = 7;
  localparam int SWF_HALF_BIT = 6;
  localparam int SWF_UF0_BIT = 5;
  localparam int SWF_BANK_HI_BIT = 4;
  localparam int SWF_BANK_LO_BIT = 3;
  localparam int SWF_RANGE_BIT = 2;
  localparam int SWF_UF1_BIT = 1;
  localparam int SWF_PARITY_BIT = 0;
  // Bank window is eight bytes wide
  localparam int SWF_BANK_SHIFT = 3;

  // ----------------------------------------------------------------
  // Arithmetic operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SWF_OP_ADD = 3'h0,
    SWF_OP_ADD_WITH_CARRY_OP = 3'h1,
    SWF_OP_SUBTRACT_WITH_BORROW_OP = 3'h2,
    SWF_OP_MUL = 3'h3,
    SWF_OP_DIV = 3'h4
  } swf_op_t;

  typedef struct packed {
    logic valid;
    swf_op_t code;
    logic [7:0] src;
  } swf_op_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swf_sfr_req_t;

endpackage : swf_pkg

// ---- hw/swf_status_word.sv ----
// Purpose: Status word flags and accumulator of an 8-bit core
// Assumes: Requests come from core logic on CLK, so no synchronisers
// Notes: Arithmetic result has priority over a same-cycle register write to the bits it sets
`timescale 1ns/1ps
module swf_status_word
  import swf_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire swf_op_req_t OP_REQ,
  input wire swf_sfr_req_t SFR_REQ,
  output logic [DATA_W-1:0] SFR_RDATA,
  output logic [DATA_W-1:0] ACC_OUT,
  output logic [DATA_W-1:0] PSW_OUT,
  output logic [DATA_W-1:0] AUX_OUT,
  output logic [4:0] BANK_BASE
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != 8) begin : g_bad_width
    $error("swf_status_word supports only DATA_W of 8");
  end

  if (SWF_BANK_SHIFT + 2 > 5) begin : g_bad_shift
    $error("swf_status_word bank base does not fit five bits");
  end

  if (SWF_PSW_RST[SWF_PARITY_BIT] != ^SWF_ACC_RST) begin : g_bad_parity_rst
    $error("swf_status_word reset parity disagrees with reset accumulator");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic half_q, half_d;
  logic range_q, range_d;
  logic uf0_q, uf0_d;
  logic uf1_q, uf1_d;
  logic [1:0] bank_q, bank_d;
  logic parity_q;
  logic [7:0] aux_q, aux_d;
  logic [7:0] rdata_q;
  logic [4:0] base_q;
  logic parity_d;
  logic [4:0] base_d;

  // ----------------------------------------------------------------
  // Arithmetic datapath
  // ----------------------------------------------------------------
  wire [7:0] a = acc_q;
  wire [7:0] b = OP_REQ.src;
  wire cin = (OP_REQ.code == SWF_OP_ADD) ? 1'b0 : carry_q;
  wire [8:0] add_sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  wire [4:0] add_nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  wire [8:0] sub_dif = {1'b0, a} - {1'b0, b} - {8'h00, carry_q};
  wire [4:0] sub_nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, carry_q};
  wire [15:0] product = {8'h00, a} * {8'h00, b};
  wire div_zero = (b == 8'h00);
  wire [7:0] quot = div_zero ? a : a / b;
  wire [7:0] remd = div_zero ? 8'h00 : a % b;
  wire add_ovf = (a[7] == b[7]) && (add_sum[7] != a[7]);
  wire sub_ovf = (a[7] != b[7]) && (sub_dif[7] != a[7]);

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire wr_psw = SFR_REQ.wr && (SFR_REQ.addr == SWF_PSW_ADDR);
  wire wr_acc = SFR_REQ.wr && (SFR_REQ.addr == SWF_ACC_ADDR);
  wire [7:0] wd = SFR_REQ.wdata;
  wire [7:0] psw_now = {carry_q, half_q, uf0_q, bank_q, range_q, uf1_q, parity_q};
  wire [7:0] rd_sel = (SFR_REQ.addr == SWF_PSW_ADDR) ? psw_now :
                      (SFR_REQ.addr == SWF_ACC_ADDR) ? acc_q : 8'h00;

  // An op result overrides a same-cycle write to the same bits
  always_comb begin
    acc_d = wr_acc ? wd : acc_q;
    carry_d = wr_psw ? wd[SWF_CARRY_BIT] : carry_q;
    half_d = wr_psw ? wd[SWF_HALF_BIT] : half_q;
    range_d = wr_psw ? wd[SWF_RANGE_BIT] : range_q;
    uf0_d = wr_psw ? wd[SWF_UF0_BIT] : uf0_q;
    uf1_d = wr_psw ? wd[SWF_UF1_BIT] : uf1_q;
    bank_d = wr_psw ? {wd[SWF_BANK_HI_BIT], wd[SWF_BANK_LO_BIT]} : bank_q;
    aux_d = aux_q;
    if (OP_REQ.valid) begin
      case (OP_REQ.code)
        SWF_OP_ADD, SWF_OP_ADD_WITH_CARRY_OP: begin
          acc_d = add_sum[7:0];
          carry_d = add_sum[8];
          half_d = add_nib[4];
          range_d = add_ovf;
        end
        SWF_OP_SUBTRACT_WITH_BORROW_OP: begin
          acc_d = sub_dif[7:0];
          carry_d = sub_dif[8];
          half_d = sub_nib[4];
          range_d = sub_ovf;
        end
        SWF_OP_MUL: begin
          acc_d = product[7:0];
          aux_d = product[15:8];
          carry_d = 1'b0;
          half_d = 1'b0;
          range_d = |product[15:8];
        end
        SWF_OP_DIV: begin
          acc_d = quot;
          aux_d = remd;
          carry_d = 1'b0;
          half_d = 1'b0;
          range_d = div_zero;
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Derived next values
  // ----------------------------------------------------------------
  // Taken from next values so the outputs never lag one another
  // parity of the accumulator about to be stored
  assign parity_d = ^acc_d;
  assign base_d = 5'(bank_d) << SWF_BANK_SHIFT;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Accumulator and the high byte or remainder paired with it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc_q <= SWF_ACC_RST;
      aux_q <= SWF_AUX_RST;
    end else begin
      acc_q <= acc_d;
      aux_q <= aux_d;
    end
  end

  // Result flags, written by arithmetic or by software
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      carry_q <= SWF_PSW_RST[SWF_CARRY_BIT];
      half_q <= SWF_PSW_RST[SWF_HALF_BIT];
      range_q <= SWF_PSW_RST[SWF_RANGE_BIT];
    end else begin
      carry_q <= carry_d;
      half_q <= half_d;
      range_q <= range_d;
    end
  end

  // user flags and bank change only on writes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      uf0_q <= SWF_PSW_RST[SWF_UF0_BIT];
      uf1_q <= SWF_PSW_RST[SWF_UF1_BIT];
      bank_q <= {SWF_PSW_RST[SWF_BANK_HI_BIT], SWF_PSW_RST[SWF_BANK_LO_BIT]};
    end else begin
      uf0_q <= uf0_d;
      uf1_q <= uf1_d;
      bank_q <= bank_d;
    end
  end

  // parity has no PSW write path; it follows acc_d, so accumulator writes change it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      parity_q <= SWF_PSW_RST[SWF_PARITY_BIT];
    end else begin
      parity_q <= parity_d;
    end
  end

  // Base kept in its own flop so the output needs no shifter
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      base_q <= SWF_BASE_RST;
    end else begin
      base_q <= base_d;
    end
  end

  // Read data trails the address by one cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= SWF_RDATA_RST;
    end else begin
      rdata_q <= rd_sel;
    end
  end

  assign ACC_OUT = acc_q;
  assign PSW_OUT = {carry_q, half_q, uf0_q, bank_q, range_q, uf1_q, parity_q};
  assign AUX_OUT = aux_q;
  assign SFR_RDATA = rdata_q;
  assign BANK_BASE = base_q;

endmodule : swf_status_word

// ---- dv/swf_sva.sv ----
// Purpose: Port assertions for the status word block
// Assumes: One clock, async active-low reset
// Notes: Sums come from inputs so they are sampled at the op edge
`timescale 1ns/1ps
module swf_sva
  import swf_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire swf_op_req_t OP_REQ,
  input wire swf_sfr_req_t SFR_REQ,
  input wire logic [7:0] ACC_OUT,
  input wire logic [7:0] PSW_OUT,
  input wire logic [4:0] BANK_BASE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wire logic [8:0] sum = ACC_OUT + OP_REQ.src;
  wire logic [4:0] nib = ACC_OUT[3:0] + OP_REQ.src[3:0];
  wire logic add = OP_REQ.valid && OP_REQ.code == SWF_OP_ADD;
  wire logic dz = OP_REQ.valid && OP_REQ.code == SWF_OP_DIV && OP_REQ.src == 8'h00;
  a_carry_add: assert property (add |=> PSW_OUT[7] == $past(sum[8]))
    else $error("carry wrong");
  a_half_add: assert property (add |=> PSW_OUT[6] == $past(nib[4]))
    else $error("half carry wrong");
  a_bank_map: assert property (BANK_BASE == {PSW_OUT[4:3], 3'h0})
    else $error("bank base wrong");
  a_range_div0: assert property (dz |=> PSW_OUT[2])
    else $error("range flag clear");
  a_parity_odd: assert property (PSW_OUT[0] == ^ACC_OUT)
    else $error("parity wrong");
  a_user_hold: assert property (!SFR_REQ.wr |=> $stable({PSW_OUT[5], PSW_OUT[1]}))
    else $error("user flag moved");
  c_add: cover property (add);
  c_div0: cover property (dz);
  c_wr: cover property (SFR_REQ.wr && SFR_REQ.addr == SWF_PSW_ADDR);
endmodule : swf_sva
bind swf_status_word swf_sva u_sva (.CLK(CLK), .RESETN(RESETN), .OP_REQ(OP_REQ),
  .SFR_REQ(SFR_REQ), .ACC_OUT(ACC_OUT), .PSW_OUT(PSW_OUT), .BANK_BASE(BANK_BASE));

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the status word block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Driver queues expected words, monitor pops them
`timescale 1ns/1ps
module tb_top
  import swf_pkg::*;
;
  logic CLK = 0;
  logic RESETN = 0;
  swf_op_req_t op = '0;
  swf_sfr_req_t sfr = '0;
  logic [7:0] acc_o, psw_o, rd_o, aux_o, acc = 0, program_status_word = 0, aux = 0;
  logic [4:0] base;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  logic [31:0] x = 4667;
  int failures = 0, checked = 0, cyc = 0;
  always #2.5 CLK = ~CLK;
  swf_status_word dut (.CLK(CLK), .RESETN(RESETN), .OP_REQ(op), .SFR_REQ(sfr),
    .SFR_RDATA(rd_o), .ACC_OUT(acc_o), .PSW_OUT(psw_o), .AUX_OUT(aux_o), .BANK_BASE(base));
  function logic [7:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x[7:0];
  endfunction : rnd
  task stop_test;
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task chk(input logic [20:0] ex, input logic [20:0] got);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, ex);
    end
  endtask : chk
  task chk8(input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, ex);
    end
  endtask : chk8
  task drive(input swf_op_req_t o, input swf_sfr_req_t s);
    op = o;
    sfr = s;
    @(posedge CLK);
    #1;
  endtask : drive
  task opx(input logic [2:0] c, input logic [7:0] b);
    logic [8:0] r;
    logic [4:0] h;
    logic [15:0] p;
    logic ci;
    ci = (c != 3'h0) && program_status_word[7];
    r = (c == 3'h2) ? {1'b0, acc} - b - ci : {1'b0, acc} + b + ci;
    h = (c == 3'h2) ? {1'b0, acc[3:0]} - b[3:0] - ci : {1'b0, acc[3:0]} + b[3:0] + ci;
    p = acc * b;
    if (c == 3'h4) begin
      r = (b == 8'h00) ? {1'b0, acc} : {1'b0, acc / b};
      aux = (b == 8'h00) ? 8'h00 : acc % b;
      program_status_word = {2'h0, program_status_word[5:3], b == 8'h00, program_status_word[1], ^r[7:0]};
      acc = r[7:0];
    end else if (c == 3'h3) begin
      aux = p[15:8];
      program_status_word = {2'h0, program_status_word[5:3], |p[15:8], program_status_word[1], ^p[7:0]};
      acc = p[7:0];
    end else begin
      program_status_word = {r[8], h[4], program_status_word[5:3], ((acc[7] ^ b[7]) == (c == 3'h2)) && (r[7] != acc[7]),
        program_status_word[1], ^r[7:0]};
      acc = r[7:0];
    end
    exp_q.push_back({8'h00, aux, acc, program_status_word});
    drive({1'b1, c, b}, '0);
  endtask : opx
  task wrx(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rd;
    rd = (a == SWF_PSW_ADDR) ? program_status_word : (a == SWF_ACC_ADDR) ? acc : 8'h00;
    if (a == SWF_PSW_ADDR) program_status_word = {d[7:1], program_status_word[0]};
    if (a == SWF_ACC_ADDR) program_status_word[0] = ^d;
    if (a == SWF_ACC_ADDR) acc = d;
    exp_q.push_back({rd, aux, acc, program_status_word});
    drive('0, {1'b1, a, d});
  endtask : wrx
  always @(posedge CLK) begin
    if (op.valid || sfr.wr) begin
      #2;
      e = exp_q.pop_front();
      chk({e[15:0], e[4:3], 3'h0}, {acc_o, psw_o, base});
      chk8(e[31:24], rd_o);
      chk8(e[23:16], aux_o);
    end
  end
  // Cut a hang short
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge CLK);
    #1 RESETN = 1;
    chk(21'h0, {acc_o, psw_o, base});
    chk8(8'h00, rd_o);
    chk8(8'h00, aux_o);
    wrx(SWF_PSW_ADDR, 8'hff);
    for (int i = 0; i < 4; i++) wrx(SWF_PSW_ADDR, {3'h0, 2'(i), 3'h0});
    wrx(SWF_ACC_ADDR, 8'h7f);
    opx(3'h0, 8'h01);
    repeat (60) opx(3'(rnd() % 8'h03), rnd());
    repeat (30) begin
      wrx(SWF_ACC_ADDR, rnd());
      opx(3'h3 + 3'(rnd() % 8'h02), rnd());
    end
    opx(3'h3, 8'h00);
    opx(3'h4, 8'h00);
    wrx(8'hd1, 8'h55);
    wrx(SWF_ACC_ADDR, rnd());
    drive('0, '0);
    repeat (3) @(posedge CLK);
    stop_test();
  end
endmodule : tb_top
